/* File: rtl/smp_monitor.sv */
// smp_monitor: servo parameter bank with speed, deviation, torque and
// temperature monitors, deceleration ramp, s-curve filter, gearing and
// encoder emulation.
// assumes feedback and commands from logic on clk; overtemp from a pin.
`timescale 1ns/1ps
module smp_monitor
  import smp_pkg::*;
#(
  parameter int MS_CYCLES     = smp_pkg::MS_CYCLES_DFLT,
  parameter int SAMPLE_CYCLES = smp_pkg::SMP_CYCLES_DFLT,
  parameter int ENC_COUNTS    = 131072,
  parameter int LINE_RATE_MAX = 12288000,
  parameter int MOTOR_MAX_RPM = 6000
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // parameter access
  input  wire logic               par_req,
  input  wire logic               par_we,
  input  wire logic        [15:0] par_addr,
  input  wire logic        [31:0] par_wdata,
  output logic                    par_ack,
  output logic                    par_err,
  output logic             [31:0] par_rdata,
  // drive state
  input  wire logic               power_enable,
  input  wire logic               pv_mode,
  input  wire logic               fault_clear,
  // feedback
  input  wire logic signed [31:0] act_vel,
  input  wire logic signed [31:0] pos_dev,
  input  wire logic signed [15:0] torque_pct,
  input  wire logic               overtemp_pin,
  // motion commands
  input  wire logic        [31:0] vel_target,
  input  wire logic               cmd_step,
  input  wire logic               cmd_dir,
  input  wire logic               enc_step,
  input  wire logic               enc_dir,
  // motion outputs
  output logic             [31:0] vel_cmd,
  output logic                    motion_ok,
  output logic                    gear_step,
  output logic                    gear_dir,
  output logic                    enc_a,
  output logic                    enc_b,
  // status outputs
  output logic                    below_speed_output,
  output logic                    above_speed_output,
  output logic                    position_deviation_output,
  output logic                    regen_fitted,
  output logic                    torque_overrun_fault,
  output logic                    overtemp_alert,
  output logic                    overtemp_fault,
  output logic                    power_off_req
);

  if (MS_CYCLES < 1 || SAMPLE_CYCLES < 40 || ENC_COUNTS < 4) begin : g_chk
    $error("smp_monitor: timing or encoder parameter out of range");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************
  // parameter bank
  // ****************************************************
  logic [31:0]        regs_q [NREG];
  logic [31:0]        regs_d [NREG];
  logic               ack_q, ack_d, err_q, err_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               hit, wr_ok, locked;
  logic [4:0]         idx;
  logic signed [33:0] wval;
  logic [63:0]        lines_x4, lines_rate;

  // decode, range check and lock; refused writes leave the value alone
  always_comb begin
    hit = 1'h0;
    idx = '0;
    for (int i = 0; i < NREG; i++) begin
      if (par_addr == REG_ADDR[i]) begin
        hit = 1'h1;
        idx = 5'(i);
      end
    end
    if (REG_W16[idx]) begin
      wval = REG_SGN[idx] ? 34'(signed'(par_wdata[15:0]))
                          : {18'h0, par_wdata[15:0]};
    end else begin
      wval = REG_SGN[idx] ? 34'(signed'(par_wdata)) : {2'h0, par_wdata};
    end
    lines_x4   = {30'h0, wval} << 2;
    lines_rate = 64'(wval[31:0]) * 64'(regs_q[IDX_CEIL]);
    wr_ok = (wval >= REG_MIN[idx]) && (wval <= REG_MAX[idx]);
    if (idx == IDX_LINES) begin
      // line count bounded by count resolution and ceiling
      wr_ok = wr_ok && (lines_x4 <= 64'(ENC_COUNTS))
              && (lines_rate <= 64'(LINE_RATE_MAX));
    end
    if (idx == IDX_SCURVE) begin
      wr_ok = wr_ok && (wval % SCURVE_STEP_US == 0);
    end
    locked = REG_LOCK[idx] && power_enable;
    regs_d  = regs_q;
    ack_d   = par_req;
    err_d   = 1'h0;
    rdata_d = rdata_q;
    if (par_req) begin
      rdata_d = '0;
      if (!hit) begin
        err_d = 1'h1;
      end else if (!par_we) begin
        rdata_d = REG_W16[idx] ? {16'h0, regs_q[idx][15:0]} : regs_q[idx];
      end else if (locked || !wr_ok) begin
        err_d = 1'h1;
      end else begin
        regs_d[idx] = wval[31:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regs_q           <= REG_RST;
      regs_q[IDX_CEIL] <= 32'(MOTOR_MAX_RPM);
      ack_q            <= 1'h0;
      err_q            <= 1'h0;
      rdata_q          <= '0;
    end else begin
      regs_q  <= regs_d;
      ack_q   <= ack_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  assign par_ack   = ack_q;
  assign par_err   = err_q;
  assign par_rdata = rdata_q;

  bus_ack_a: assert property (par_req |=> par_ack)
    else $error("request not answered");
  lock_refuse_a: assert property (
    par_req && par_we && hit && REG_LOCK[idx] && power_enable |=> par_err)
    else $error("locked parameter write accepted");
  range_refuse_a: assert property (
    par_req && par_we && hit && !wr_ok |=> par_err && regs_q[$past(idx)]
      == $past(regs_q[idx]))
    else $error("out of range write accepted");

  // ****************************************************
  // timebase and monitors
  // ****************************************************
  logic [31:0] ms_cnt_q, ms_cnt_d, bsub_q, bsub_d;
  logic [9:0]  msc_q, msc_d;
  logic [15:0] brk_q, brk_d, trq_cnt_q, trq_cnt_d, ot_cnt_q, ot_cnt_d;
  logic        mok_q, mok_d, trq_flt_q, trq_flt_d, ot_flt_q, ot_flt_d;
  logic        ot_s1_q, ot_s2_q, alert_q, alert_d, off_q, off_d;
  logic        below_q, below_d, above_q, above_d, pdev_q, pdev_d;
  logic        regen_q, regen_d, ms_tick, sec_tick, trq_over;
  logic [31:0] vabs, dabs;
  logic [15:0] tabs, ot_m;
  logic [35:0] above_x10;

  assign ms_tick  = (ms_cnt_q == 32'(MS_CYCLES - 1));
  assign sec_tick = ms_tick && (msc_q == 10'(SEC_MS - 1));

  // ms and second ticks, brake delay, fault timers, speed compares
  always_comb begin
    ms_cnt_d = ms_tick ? '0 : ms_cnt_q + 32'h1;
    msc_d    = msc_q;
    if (ms_tick) begin
      msc_d = sec_tick ? '0 : msc_q + 10'h1;
    end
    // brake wait keeps its own ms count from the enable, so the free
    // running tick can never cut the wait short
    brk_d  = brk_q;
    bsub_d = bsub_q;
    mok_d  = mok_q;
    if (!power_enable) begin
      brk_d  = '0;
      bsub_d = '0;
      mok_d  = 1'h0;
    end else if (brk_q >= regs_q[IDX_BRAKE][15:0]) begin
      mok_d = 1'h1;
    end else if (bsub_q == 32'(MS_CYCLES - 1)) begin
      bsub_d = '0;
      brk_d  = brk_q + 16'h1;
    end else begin
      bsub_d = bsub_q + 32'h1;
    end
    // torque over level for the programmed ms; set wins over clear
    tabs     = 16'(torque_pct[15] ? -torque_pct : torque_pct);
    trq_over = tabs > regs_q[IDX_TLVL][15:0];
    trq_cnt_d = trq_cnt_q;
    if (!trq_over) begin
      trq_cnt_d = '0;
    end else if (ms_tick && trq_cnt_q < regs_q[IDX_TTIME][15:0]) begin
      trq_cnt_d = trq_cnt_q + 16'h1;
    end
    trq_flt_d = (trq_over && trq_cnt_q >= regs_q[IDX_TTIME][15:0])
                || (trq_flt_q && !fault_clear);
    // overtemperature response
    ot_m     = regs_q[IDX_OTMODE][15:0];
    ot_cnt_d = ot_cnt_q;
    if (!ot_s2_q || ot_m != OT_DELAYED) begin
      ot_cnt_d = '0;
    end else if (sec_tick && ot_cnt_q < regs_q[IDX_OTDLY][15:0]) begin
      ot_cnt_d = ot_cnt_q + 16'h1;
    end
    ot_flt_d = (ot_s2_q && ot_m == OT_DELAYED
                && ot_cnt_q >= regs_q[IDX_OTDLY][15:0])
               || (ot_flt_q && !fault_clear);
    alert_d = ot_s2_q && (ot_m == OT_ALERT || ot_m == OT_DELAYED);
    // codes 1 and 2 are undefined; treated as the safe immediate stop
    off_d = (ot_s2_q && ot_m < OT_IGNORE) || ot_flt_q || trq_flt_q;
    vabs      = 32'(act_vel[31] ? -act_vel : act_vel);
    dabs      = 32'(pos_dev[31] ? -pos_dev : pos_dev);
    above_x10 = ({4'h0, regs_q[IDX_ABOVE]} << 3)
                + ({4'h0, regs_q[IDX_ABOVE]} << 1);
    below_d = vabs < regs_q[IDX_BELOW];
    above_d = {4'h0, vabs} > above_x10;
    pdev_d  = dabs > regs_q[IDX_PDEV];
    regen_d = (regs_q[IDX_OHMS][15:0] != NO_RESISTOR)
              && (regs_q[IDX_WATTS][15:0] != NO_RESISTOR);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_cnt_q  <= '0;
      msc_q     <= '0;
      brk_q     <= '0;
      bsub_q    <= '0;
      mok_q     <= 1'h0;
      trq_cnt_q <= '0;
      trq_flt_q <= 1'h0;
      ot_cnt_q  <= '0;
      ot_flt_q  <= 1'h0;
      ot_s1_q   <= 1'h0;
      ot_s2_q   <= 1'h0;
      alert_q   <= 1'h0;
      off_q     <= 1'h0;
      below_q   <= 1'h0;
      above_q   <= 1'h0;
      pdev_q    <= 1'h0;
      regen_q   <= 1'h0;
    end else begin
      ms_cnt_q  <= ms_cnt_d;
      msc_q     <= msc_d;
      brk_q     <= brk_d;
      bsub_q    <= bsub_d;
      mok_q     <= mok_d;
      trq_cnt_q <= trq_cnt_d;
      trq_flt_q <= trq_flt_d;
      ot_cnt_q  <= ot_cnt_d;
      ot_flt_q  <= ot_flt_d;
      ot_s1_q   <= overtemp_pin; // pin synchroniser
      ot_s2_q   <= ot_s1_q;
      alert_q   <= alert_d;
      off_q     <= off_d;
      below_q   <= below_d;
      above_q   <= above_d;
      pdev_q    <= pdev_d;
      regen_q   <= regen_d;
    end
  end

  assign motion_ok                 = mok_q;
  assign torque_overrun_fault      = trq_flt_q;
  assign overtemp_alert            = alert_q;
  assign overtemp_fault            = ot_flt_q;
  assign power_off_req             = off_q;
  assign below_speed_output        = below_q;
  assign above_speed_output        = above_q;
  assign position_deviation_output = pdev_q;
  assign regen_fitted              = regen_q;

  brake_wait_a: assert property (
    $rose(power_enable) && regs_q[IDX_BRAKE][15:0] != 16'h0
    |-> !motion_ok [*2])
    else $error("motion allowed before brake delay");
  above_cmp_a: assert property (
    above_speed_output == ({4'h0, $past(vabs)}
      > 36'($past(regs_q[IDX_ABOVE])) * 36'd10))
    else $error("above-speed output wrong");
  below_cmp_a: assert property (
    !power_enable && vabs < regs_q[IDX_BELOW] |=> below_speed_output)
    else $error("below-speed output missing");
  torque_time_a: assert property (
    $rose(torque_overrun_fault) |->
      $past(trq_cnt_q) >= $past(regs_q[IDX_TTIME][15:0]))
    else $error("torque fault too early");
  ot_stop_a: assert property (
    ot_s2_q && regs_q[IDX_OTMODE][15:0] == 16'h0 |=> power_off_req)
    else $error("overtemp stop missing");
  ot_delay_a: assert property (
    $rose(overtemp_fault) |->
      $past(ot_cnt_q) >= $past(regs_q[IDX_OTDLY][15:0]))
    else $error("overtemp fault before delay");
  regen_none_a: assert property (
    regen_fitted |-> $past(regs_q[IDX_OHMS][15:0]) != NO_RESISTOR)
    else $error("resistor reported with value minus one");

  // ****************************************************
  // ramp, gearing and encoder emulation
  // ****************************************************
  logic [31:0]        ramp_q, ramp_d, tgt;
  logic [47:0]        racc_q, racc_d, racc_n, rlim;
  logic [33:0]        gacc_q, gacc_d;
  logic               gstep_q, gstep_d, gdir_q, gdir_d;
  logic signed [33:0] eacc_q, eacc_d, einc;
  logic [1:0]         ab_q, ab_d, ebin;
  logic [35:0]        ceil10;

  // decel slope: DEC_REF_UNITS of 0.1 rpm per programmed ms
  always_comb begin
    ceil10 = ({4'h0, regs_q[IDX_CEIL]} << 3) + ({4'h0, regs_q[IDX_CEIL]} << 1);
    tgt    = ({4'h0, vel_target} > ceil10) ? ceil10[31:0] : vel_target;
    if (!mok_q) begin
      tgt = '0;
    end
    racc_n = racc_q + 48'(DEC_REF_UNITS);
    rlim   = 48'(regs_q[IDX_DECEL][15:0]) * 48'(MS_CYCLES);
    ramp_d = ramp_q;
    racc_d = racc_n;
    if (tgt >= ramp_q) begin
      ramp_d = tgt;
      racc_d = '0;
    end else if (racc_n >= rlim) begin
      ramp_d = ramp_q - 32'h1;
      racc_d = racc_n - rlim;
    end
    // gear: add numerator per input step, emit one step per denominator
    gacc_d  = gacc_q;
    gdir_d  = gdir_q;
    gstep_d = 1'h0;
    if (gacc_q >= {2'h0, regs_q[IDX_GDEN]}) begin
      gacc_d  = gacc_q - {2'h0, regs_q[IDX_GDEN]};
      gstep_d = 1'h1;
    end
    if (cmd_step) begin
      gacc_d = gacc_d + {2'h0, regs_q[IDX_GNUM]};
      gdir_d = cmd_dir;
    end
    // encoder: one quadrature edge per ENC_COUNTS/(4*lines) counts
    einc   = 34'(regs_q[IDX_LINES]) <<< 2;
    eacc_d = eacc_q;
    ebin   = {ab_q[1], ab_q[1] ^ ab_q[0]};
    if (enc_step && !enc_dir) begin
      eacc_d = eacc_q + einc;
      if (eacc_d >= 34'(ENC_COUNTS)) begin
        eacc_d = eacc_d - 34'(ENC_COUNTS);
        ebin   = ebin + 2'h1;
      end
    end else if (enc_step) begin
      eacc_d = eacc_q - einc;
      if (eacc_d < 0) begin
        eacc_d = eacc_d + 34'(ENC_COUNTS);
        ebin   = ebin - 2'h1;
      end
    end
    ab_d = {ebin[1], ebin[1] ^ ebin[0]};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_q  <= '0;
      racc_q  <= '0;
      gacc_q  <= '0;
      gdir_q  <= 1'h0;
      gstep_q <= 1'h0;
      eacc_q  <= '0;
      ab_q    <= 2'h0;
    end else begin
      ramp_q  <= ramp_d;
      racc_q  <= racc_d;
      gacc_q  <= gacc_d;
      gdir_q  <= gdir_d;
      gstep_q <= gstep_d;
      eacc_q  <= eacc_d;
      ab_q    <= ab_d;
    end
  end

  assign gear_step = gstep_q;
  assign gear_dir  = gdir_q;
  assign enc_a     = ab_q[1];
  assign enc_b     = ab_q[0];

  decel_step_a: assert property (
    ramp_q < $past(ramp_q) |-> $past(ramp_q) - ramp_q == 32'h1)
    else $error("ramp fell faster than one unit");
  quad_edge_a: assert property (
    $countones(ab_q ^ $past(ab_q)) <= 1)
    else $error("quadrature skipped a state");

  // ****************************************************
  // s-curve moving average
  // ****************************************************
  smp_sc_state_t st_q, st_d;
  logic [31:0]   scnt_q, scnt_d, smp_q, smp_d, sum_q, sum_d, old;
  logic [31:0]   quo_q, quo_d, vcmd_q, vcmd_d, mem_q;
  logic [32:0]   rem_q, rem_d;
  logic [10:0]   wptr_q, wptr_d, fill_q, fill_d, sc_n;
  logic [4:0]    dcnt_q, dcnt_d;
  logic          smp_tick, mem_rd, mem_wr, filt_on;

  assign sc_n     = 11'(regs_q[IDX_SCURVE] / SCURVE_STEP_US);
  assign smp_tick = (scnt_q == 32'(SAMPLE_CYCLES - 1));
  assign filt_on  = pv_mode && (sc_n != 11'h0);

  // one sample per step: read oldest, update sum, divide serially
  always_comb begin
    scnt_d = smp_tick ? '0 : scnt_q + 32'h1;
    st_d   = st_q;
    smp_d  = smp_q;
    sum_d  = sum_q;
    wptr_d = wptr_q;
    fill_d = fill_q;
    rem_d  = rem_q;
    quo_d  = quo_q;
    dcnt_d = dcnt_q;
    vcmd_d = vcmd_q;
    mem_rd = 1'h0;
    mem_wr = 1'h0;
    old    = (fill_q >= sc_n) ? mem_q : '0;
    unique case (st_q)
      SC_IDLE: begin
        if (smp_tick) begin
          smp_d  = ramp_q;
          mem_rd = 1'h1;
          st_d   = SC_READ;
        end
      end
      SC_READ: begin
        sum_d  = sum_q + smp_q - old;
        mem_wr = 1'h1;
        wptr_d = wptr_q + 11'h1;
        fill_d = (fill_q < sc_n) ? fill_q + 11'h1 : fill_q;
        rem_d  = '0;
        quo_d  = sum_d;
        dcnt_d = '0;
        st_d   = SC_DIV;
      end
      SC_DIV: begin
        rem_d = {rem_q[31:0], quo_q[31]};
        quo_d = {quo_q[30:0], 1'h0};
        if (rem_d >= {22'h0, sc_n}) begin
          rem_d    = rem_d - {22'h0, sc_n};
          quo_d[0] = 1'h1;
        end
        dcnt_d = dcnt_q + 5'h1;
        if (dcnt_q == 5'h1F) begin
          vcmd_d = quo_d;
          st_d   = SC_IDLE;
        end
      end
      default: st_d = SC_IDLE;
    endcase
    // history restarts with each enable; time is locked meanwhile
    if (!power_enable) begin
      sum_d  = '0;
      fill_d = '0;
    end
    if (!filt_on) begin
      vcmd_d = ramp_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= SC_IDLE;
      scnt_q <= '0;
      smp_q  <= '0;
      sum_q  <= '0;
      wptr_q <= '0;
      fill_q <= '0;
      rem_q  <= '0;
      quo_q  <= '0;
      dcnt_q <= '0;
      vcmd_q <= '0;
    end else begin
      st_q   <= st_d;
      scnt_q <= scnt_d;
      smp_q  <= smp_d;
      sum_q  <= sum_d;
      wptr_q <= wptr_d;
      fill_q <= fill_d;
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      dcnt_q <= dcnt_d;
      vcmd_q <= vcmd_d;
    end
  end

  assign vel_cmd = vcmd_q;

  smp_ram #(
    .W  (32),
    .AW (11)
  ) u_hist (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (mem_wr),
    .wr_addr (wptr_q),
    .wr_data (smp_q),
    .rd_en   (mem_rd),
    .rd_addr (wptr_q - sc_n),
    .rd_data (mem_q)
  );

endmodule

/* File: rtl/smp_pkg.sv */
// smp_pkg: parameter map, limits, reset values and timing of the servo
// motion parameter block.
// assumes word-addressed parameter access from the fieldbus side.
// Function
// - decel ramp: reference speed to standstill in programmed ms
// - below-speed output high while actual speed under threshold in 0.1 rpm
// - above-speed output high while actual speed over threshold in rpm
// - after power stage enable, wait brake release delay before any movement; only the velocity target is held at zero, gear and encoder steps are not gated
// - position steps scaled by gear numerator over gear denominator
// - denominator, encoder lines, ceiling, s-curve time locked while powered
// - emulated quadrature a/b output at programmed lines per revolution
// - braking resistor value minus one means no resistor fitted
// - position deviation output against programmed trigger value
// - velocity command limited to user ceiling in rpm
// - torque overrun fault when torque above level longer than time
// - profile velocity command smoothed by moving average, 125 us steps
// - overtemperature response: 0 disable, 3 ignore, 4 alert, 5 delayed
// - delayed response waits programmed seconds before fault
// - inertia ratio held in tenths, factory 10, bounded
// - commutation time and velocity thresholds held with factory values
package smp_pkg;

  // ****************************************************
  // parameter map
  // ****************************************************
  localparam int NREG       = 19;
  localparam int IDX_DECEL  = 0;
  localparam int IDX_BELOW  = 2;
  localparam int IDX_ABOVE  = 3;
  localparam int IDX_BRAKE  = 4;
  localparam int IDX_GNUM   = 5;
  localparam int IDX_GDEN   = 6;
  localparam int IDX_LINES  = 7;
  localparam int IDX_OHMS   = 8;
  localparam int IDX_WATTS  = 9;
  localparam int IDX_PDEV   = 10;
  localparam int IDX_CEIL   = 11;
  localparam int IDX_TLVL   = 12;
  localparam int IDX_TTIME  = 13;
  localparam int IDX_SCURVE = 14;
  localparam int IDX_OTMODE = 17;
  localparam int IDX_OTDLY  = 18;

  localparam logic [15:0] REG_ADDR [NREG] = '{
    16'h0246, 16'h024A, 16'h024C, 16'h024E, 16'h0254, 16'h0258, 16'h025A,
    16'h025C, 16'h0268, 16'h026A, 16'h026C, 16'h026E, 16'h0272, 16'h0274,
    16'h0276, 16'h0278, 16'h027A, 16'h027C, 16'h027E};
  localparam logic signed [33:0] REG_MIN [NREG] = '{
    6, 0, 0, 0, 0, 1, 1, 1, -1, -1, 0, 10, 0, 1, 0, 0, 0, 0, 0};
  localparam logic signed [33:0] REG_MAX [NREG] = '{
    65500, 20000, 2000, 5000, 1000, 536870911, 2147483647, 2147483647,
    32767, 32767, 1280000, 6000, 300, 1000, 255875, 3000, 60000, 5, 300};
  localparam logic [31:0] REG_RST [NREG] = '{
    32'h1E, 32'hA, 32'h64, 32'hBB8, 32'h0, 32'h1, 32'h20000, 32'h800,
    32'hFFFF, 32'hFFFF, 32'h51F, 32'h1770, 32'h0, 32'h1, 32'h0, 32'h0,
    32'h258, 32'h0, 32'h1E};
  // 16-bit, signed and power-locked parameters
  localparam bit REG_W16 [NREG] = '{
    1, 0, 0, 0, 1, 0, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 1};
  localparam bit REG_SGN [NREG] = '{
    0, 0, 1, 0, 0, 0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  localparam bit REG_LOCK [NREG] = '{
    0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 1, 0, 0, 1, 0, 0, 0, 0};

  // ****************************************************
  // timing and units
  // ****************************************************
  localparam int CLK_NS         = 10;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES_DFLT = MS_NS / CLK_NS;
  localparam int SEC_MS         = 1000;
  localparam int SCURVE_STEP_US = 125;
  localparam int SMP_CYCLES_DFLT = SCURVE_STEP_US * 1000 / CLK_NS;
  localparam int DEC_REF_UNITS  = 60000;
  localparam logic [15:0] NO_RESISTOR = 16'hFFFF;

  // overtemperature response codes
  localparam logic [15:0] OT_IGNORE  = 16'h3;
  localparam logic [15:0] OT_ALERT   = 16'h4;
  localparam logic [15:0] OT_DELAYED = 16'h5;

  typedef enum logic [1:0] {
    SC_IDLE = 2'h0,
    SC_READ = 2'h1,
    SC_DIV  = 2'h2
  } smp_sc_state_t;

endpackage

/* File: rtl/smp_ram.sv */
// smp_ram: simple dual-port sample memory with registered read data.
// assumes one write and one read port on the same clock.
`timescale 1ns/1ps
module smp_ram #(
  parameter int W  = 32,
  parameter int AW = 11
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  logic [W-1:0] mem [2**AW];

  // array carries no reset; readers must not trust unwritten words
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data registered, cleared only by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

/* File: verification/smp_far.sv */
// smp_far: motor shaft and temperature sensor beyond the monitor.
// assumes the bench sets the wanted speed and heat between clock edges.
`timescale 1ns/1ps
module smp_far (
  // clock
  input  wire logic               clk,
  // bench settings
  input  wire logic signed [31:0] vel_set,
  input  wire logic               hot_set,
  // feedback
  output logic signed      [31:0] act_vel,
  output logic                    overtemp_pin
);
  // shaft and sensor lag one cycle, no kinder than a real loop
  always_ff @(posedge clk) begin
    act_vel      <= vel_set;
    overtemp_pin <= hot_set;
  end
endmodule

/* File: verification/testbench.sv */
// testbench: parameter access and monitor outputs of smp_monitor.
// assumes smp_pkg compiled first; ms shortened to 10 cycles.
`timescale 1ns/1ps
module testbench;
  import smp_pkg::*;
  logic               clk, rst, par_req, par_we, par_ack, par_err, hot_set;
  logic        [15:0] par_addr;
  logic        [31:0] par_wdata, par_rdata, vel_target, vel_cmd;
  logic               power_enable, pv_mode, fault_clear, motion_ok;
  logic               cmd_step, cmd_dir, enc_step, enc_dir, overtemp_pin;
  logic               below_speed_output, above_speed_output;
  logic               position_deviation_output, overtemp_alert;
  logic               gear_step, enc_a, enc_b, regen_fitted, overtemp_fault;
  logic               torque_overrun_fault, power_off_req;
  logic signed [31:0] vel_set, act_vel, pos_dev;
  logic signed [15:0] torque_pct;
  int                 n_mismatch, samples_checked, i, n;

  smp_far smp_far_inst (.clk, .vel_set, .hot_set, .act_vel, .overtemp_pin);
  smp_monitor #(.MS_CYCLES(10), .SAMPLE_CYCLES(64)) smp_monitor_inst (
    .clk, .rst, .par_req, .par_we, .par_addr, .par_wdata, .par_ack,
    .par_err, .par_rdata, .power_enable, .pv_mode, .fault_clear, .act_vel,
    .pos_dev, .torque_pct, .overtemp_pin, .vel_target, .cmd_step, .cmd_dir,
    .enc_step, .enc_dir, .vel_cmd, .motion_ok, .gear_step, .gear_dir(),
    .enc_a, .enc_b, .below_speed_output, .above_speed_output,
    .position_deviation_output, .regen_fitted, .torque_overrun_fault,
    .overtemp_alert, .overtemp_fault, .power_off_req);

  // ***********************************
  // tasks
  // ***********************************
  task automatic conclude;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  // one access; idle cycle after it so the strobe never toggles twice
  task automatic acc(logic we, logic [15:0] a, logic [31:0] d, logic e);
    par_req = 1;
    par_we = we;
    par_addr = a;
    par_wdata = d;
    @(posedge clk);
    #1;
    par_req = 0;
    chk("ack", 1, par_ack);
    chk("err", e, par_err);
    @(posedge clk);
    #1;
  endtask
  // partner lag plus registered output: settled within three edges
  task automatic mon(int v, int p, logic b, logic a, logic d);
    vel_set = v;
    pos_dev = p;
    repeat (3) @(posedge clk);
    #1;
    chk("below", b, below_speed_output);
    chk("above", a, above_speed_output);
    chk("deviation", d, position_deviation_output);
  endtask

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    {rst, par_req, par_we, power_enable, pv_mode, fault_clear} = 6'h20;
    {hot_set, cmd_step, cmd_dir, enc_step, enc_dir} = 5'h0;
    {par_addr, par_wdata, vel_target, vel_set, pos_dev} = '0;
    torque_pct = '0;
    repeat (20) @(posedge clk);
    #1;
    rst = 0;
    for (i = 0; i < NREG; i++) begin
      acc(0, REG_ADDR[i], 0, 0);
      chk("reset", REG_RST[i] & (REG_W16[i] ? 32'hFFFF : 32'hFFFFFFFF),
          par_rdata & (REG_W16[i] ? 32'hFFFF : 32'hFFFFFFFF));
    end
    acc(0, 16'h0248, 0, 1);
    acc(1, 16'h0246, 32'h5, 1);
    acc(1, 16'h0246, 32'hFFDD, 1);
    acc(1, 16'h0246, 32'hFFDC, 0);
    acc(0, 16'h0246, 0, 0);
    chk("decel", 32'hFFDC, par_rdata);
    chk("regen", 0, regen_fitted);
    acc(1, 16'h0268, 32'h64, 0);
    acc(1, 16'h026A, 32'hC8, 0);
    chk("regen", 1, regen_fitted);
    $display("register test done");
    acc(1, 16'h0254, 32'h3, 0);
    power_enable = 1;
    n = 0;
    while (motion_ok !== 1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 100) begin
        chk("motion_ok", 1, motion_ok);
        conclude();
      end
    end
    chk("brake", 1, 32'(n >= 29 && n <= 32));
    vel_target = 100;
    repeat (3) @(posedge clk);
    #1;
    chk("vel_cmd", 100, vel_cmd);
    vel_target = 0;
    repeat (120) @(posedge clk);
    #1;
    chk("vel_cmd", 90, vel_cmd);
    acc(1, 16'h025A, 32'h5, 1);
    acc(0, 16'h025A, 0, 0);
    chk("gear_den", 32'h20000, par_rdata);
    power_enable = 0;
    acc(1, 16'h025A, 32'h5, 0);
    n = 0;
    for (i = 0; i < 16; i++) begin
      {cmd_step, enc_step} = 2'h3;
      @(posedge clk);
      #1;
      {cmd_step, enc_step} = 2'h0;
      @(posedge clk);
      #1;
      n += gear_step;
    end
    chk("gear_steps", 3, n);
    chk("quadrature", 1, {enc_a, enc_b});
    $display("lock test done");
    mon(99, 1311, 1, 0, 0);
    mon(100, 0, 0, 0, 0);
    mon(30001, 1312, 0, 1, 1);
    mon(-30001, -1312, 0, 1, 1);
    mon(30000, 0, 0, 0, 0);
    acc(1, 16'h027C, 32'h6, 1);
    acc(1, 16'h027E, 32'h1, 0);
    for (i = 3; i < 6; i++) begin
      acc(1, 16'h027C, 32'(i), 0);
      hot_set = 1;
      repeat (5) @(posedge clk);
      #1;
      chk("alert", 32'(i >= 4), overtemp_alert);
      hot_set = 0;
    end
    {hot_set, torque_pct} = 17'h1000A;
    n = 0;
    while (overtemp_fault !== 1 || n < 30) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 25000) begin
        chk("ot_fault", 1, overtemp_fault);
        conclude();
      end
    end
    {hot_set, torque_pct} = 17'h0;
    repeat (5) @(posedge clk);
    #1;
    chk("ot_fault", 1, overtemp_fault);
    chk("torque", 1, torque_overrun_fault);
    chk("power_off", 1, power_off_req);
    fault_clear = 1;
    repeat (3) @(posedge clk);
    #1;
    chk("power_off", 0, power_off_req);
    fault_clear = 0;
    acc(1, 16'h027C, 32'h0, 0);
    hot_set = 1;
    repeat (5) @(posedge clk);
    #1;
    chk("power_off", 1, power_off_req);
    $display("monitor test done");
    conclude();
  end
endmodule
